// File: lock_fault_defines.vh
// Register offsets, field positions, reset values and timing constants for lock fault response
`ifndef LOCK_FAULT_DEFINES_VH
`define LOCK_FAULT_DEFINES_VH

`define FAULT_SETTINGS_FIRST_OFS 8'h90
`define FAULT_SETTINGS_SECOND_OFS 8'h92
`define FAULT_SETTINGS_FIRST_RST 32'h00000000
`define FAULT_SETTINGS_SECOND_RST 32'h00000000

`define LRI_MSB 10
`define LRI_LSB 7
`define LRM_MSB 6
`define LRM_LSB 3
`define PD_TIMEOUT_EN_BIT 2
`define PD_FREQ_EN_BIT 1
`define SAT_EN_BIT 0
`define RETRY_LIMIT_MSB 2
`define RETRY_LIMIT_LSB 0

`define CLK_MHZ 250
`define RETRY_300_MS 300
`define RETRY_500_MS 500
`define RETRY_STEP_MS 1000
`define MS_CYCLES (`CLK_MHZ * 1000)

`define DRV_RUN 2'h0
`define DRV_TRISTATE 2'h1
`define DRV_HS_BRAKE 2'h2
`define DRV_LS_BRAKE 2'h3

`endif

// File: motor_lock_fault_response.v
// Motor lock fault reaction logic with configuration registers
//
// Overview of operation
// - Modes 0,1: latch fault, assert fault, tristate
// - Mode 2: latch fault, assert fault, high-side brake
// - Mode 3: latch fault, assert fault, low-side brake
// - Modes 4,5: auto clear after retry interval
// - Retries over limit latch fault; 4,5 tristate
// - Mode 6: retries, then latched high-side brake
// - Mode 7: retries, then latched low-side brake
// - Mode 8: report only, drivers unchanged
// - Modes 9 to 15: lock detection disabled
// - Position detect timeout fault needs enable
// - Position detect frequency fault needs enable
// - Loop saturation flags need enable bit
// - Second settings register at 0x92, resets zero
// - Retry interval codes: 300ms, 500ms, 1-14s
`timescale 1ns/100ps
`include "lock_fault_defines.vh"

module motor_lock_fault_response #(
    parameter MS_COUNT = `MS_CYCLES,
    parameter RETRY_W = 3
)(
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    input wire lock_detect,
    input wire pd_timeout_event,
    input wire pd_freq_event,
    input wire current_loop_sat,
    input wire speed_loop_sat,
    input wire fault_clear,
    output reg fault_out_n,
    output reg [1:0] drive_state,
    output reg lock_fault_active,
    output reg lock_fault_latched,
    output reg pd_timeout_fault,
    output reg pd_freq_fault,
    output reg current_loop_sat_flag,
    output reg speed_loop_sat_flag,
    output reg [RETRY_W:0] retry_count
);

    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_LATCHED = 2'h2;
    localparam ST_REPORT = 2'h3;

    reg [31:0] settings_first_q;
    reg [31:0] settings_second_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [13:0] ms_left_q;
    reg [17:0] sub_q;
    wire ms_tick;

    wire [3:0] lock_mode = settings_first_q[`LRM_MSB:`LRM_LSB];
    wire [3:0] retry_code = settings_first_q[`LRI_MSB:`LRI_LSB];
    wire [RETRY_W-1:0] retry_limit = settings_second_q[`RETRY_LIMIT_MSB:`RETRY_LIMIT_LSB];

    // Retry interval in milliseconds for a 4-bit code
    function [13:0] retry_ms;
        input [3:0] code;
        begin
            case (code)
                4'h0: retry_ms = 14'd`RETRY_300_MS;
                4'h1: retry_ms = 14'd`RETRY_500_MS;
                default: retry_ms = ({10'h000, code} - 14'h0001) * 14'd`RETRY_STEP_MS;
            endcase
        end
    endfunction

    // Latched driver state a lock mode ends in
    function [1:0] final_drive;
        input [3:0] mode;
        begin
            case (mode)
                4'h2, 4'h6: final_drive = `DRV_HS_BRAKE;
                4'h3, 4'h7: final_drive = `DRV_LS_BRAKE;
                default: final_drive = `DRV_TRISTATE;
            endcase
        end
    endfunction

    wire retry_mode = (lock_mode >= 4'h4) && (lock_mode <= 4'h7);
    wire latch_mode = (lock_mode <= 4'h3);
    wire report_mode = (lock_mode == 4'h8);

    // Register writes; reads return stored values
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            settings_first_q <= `FAULT_SETTINGS_FIRST_RST;
            settings_second_q <= `FAULT_SETTINGS_SECOND_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `FAULT_SETTINGS_FIRST_OFS)
                settings_first_q <= reg_wdata;
            if (reg_addr == `FAULT_SETTINGS_SECOND_OFS)
                settings_second_q <= reg_wdata;
        end
    end

    // Read data trails the address by one cycle; unmapped offsets read as zero
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 32'h00000000;
        end
        else if (reg_addr == `FAULT_SETTINGS_FIRST_OFS)
        begin
            reg_rdata <= settings_first_q;
        end
        else if (reg_addr == `FAULT_SETTINGS_SECOND_OFS)
        begin
            reg_rdata <= settings_second_q;
        end
        else
        begin
            reg_rdata <= 32'h00000000;
        end
    end

    // Millisecond enable; runs only while waiting so each retry interval starts aligned
    localparam [31:0] MS_LAST = MS_COUNT - 1;
    assign ms_tick = (state_q == ST_WAIT) && (sub_q == MS_LAST[17:0]);

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sub_q <= 18'h00000;
        end
        else if (state_q != ST_WAIT || ms_tick)
        begin
            sub_q <= 18'h00000;
        end
        else
        begin
            sub_q <= sub_q + 18'h00001;
        end
    end

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (lock_detect)
                begin
                    if (latch_mode)
                        state_d = ST_LATCHED;
                    else if (retry_mode)
                        state_d = (retry_count > {1'b0, retry_limit}) ? ST_LATCHED : ST_WAIT;
                    else if (report_mode)
                        state_d = ST_REPORT;
                end
            end
            ST_WAIT:
            begin
                if (!retry_mode)
                    state_d = ST_IDLE;
                else if (ms_tick && ms_left_q == 14'h0001)
                    state_d = ST_IDLE;
            end
            ST_LATCHED:
            begin
                if (fault_clear)
                    state_d = ST_IDLE;
            end
            ST_REPORT:
            begin
                if (!lock_detect || !report_mode)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            ms_left_q <= 14'h0000;
            retry_count <= {(RETRY_W+1){1'b0}};
            drive_state <= `DRV_RUN;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == ST_IDLE && state_d == ST_WAIT)
            begin
                ms_left_q <= retry_ms(retry_code);
                retry_count <= retry_count + 1'b1;
            end
            else if (ms_tick)
                ms_left_q <= ms_left_q - 14'h0001;
            if (state_q == ST_LATCHED && fault_clear)
                retry_count <= {(RETRY_W+1){1'b0}};
            case (state_d)
                ST_LATCHED: drive_state <= final_drive(lock_mode);
                ST_WAIT: drive_state <= `DRV_TRISTATE;
                default: drive_state <= `DRV_RUN;
            endcase
        end
    end

    // Enables for the sticky faults and saturation flags; qualified events shared by the sticky faults and the fault pin
    wire timeout_en = settings_first_q[`PD_TIMEOUT_EN_BIT];
    wire freq_en = settings_first_q[`PD_FREQ_EN_BIT];
    wire sat_en = settings_first_q[`SAT_EN_BIT];
    wire timeout_set = pd_timeout_event && timeout_en;
    wire freq_set = pd_freq_event && freq_en;
    // A fault seen over the clear edge would otherwise hold the pin low one extra cycle
    wire timeout_held = pd_timeout_fault && !fault_clear;
    wire freq_held = pd_freq_fault && !fault_clear;
    wire pd_fault_next = timeout_set || timeout_held || freq_set || freq_held;

    // Position detect faults are sticky; a new event wins over a clear in the same cycle
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pd_timeout_fault <= 1'b0;
        end
        else if (timeout_set)
        begin
            pd_timeout_fault <= 1'b1;
        end
        else if (fault_clear || !timeout_en)
        begin
            pd_timeout_fault <= 1'b0;
        end
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pd_freq_fault <= 1'b0;
        end
        else if (freq_set)
        begin
            pd_freq_fault <= 1'b1;
        end
        else if (fault_clear || !freq_en)
        begin
            pd_freq_fault <= 1'b0;
        end
    end

    // Saturation flags follow the raw levels gated by the enable bit, one cycle later; they are not sticky
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            current_loop_sat_flag <= 1'b0;
            speed_loop_sat_flag <= 1'b0;
        end
        else
        begin
            current_loop_sat_flag <= current_loop_sat && sat_en;
            speed_loop_sat_flag <= speed_loop_sat && sat_en;
        end
    end

    // Status follows the next state so it lines up with drive_state
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lock_fault_active <= 1'b0;
            lock_fault_latched <= 1'b0;
        end
        else
        begin
            lock_fault_active <= (state_d != ST_IDLE);
            lock_fault_latched <= (state_d == ST_LATCHED);
        end
    end

    // Any lock state but idle, or an enabled position fault, pulls the pin low
    wire lock_pending = (state_d != ST_IDLE);

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fault_out_n <= 1'b1;
        end
        else
        begin
            fault_out_n <= !(lock_pending || pd_fault_next);
        end
    end

endmodule

// File: lock_fault_monitor.sv
// Port checker for the lock fault response block
`timescale 1ns/100ps
module lock_fault_monitor (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [31:0] reg_wdata,
    input wire lock_detect,
    input wire fault_clear,
    input wire fault_out_n,
    input wire [1:0] drive_state,
    input wire lock_fault_active,
    input wire lock_fault_latched,
    input wire current_loop_sat,
    input wire current_loop_sat_flag
);
    reg [3:0] mode_q;
    wire new_lock = lock_detect && !lock_fault_active;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Mode is not a port, so it is shadowed from the writes
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
            mode_q <= 4'h0;
        else if (reg_wr && reg_addr == 8'h90)
            mode_q <= reg_wdata[6:3];
    a_float_latch: assert property (new_lock && mode_q < 4'h2 |=>
        drive_state == 2'h1 && !fault_out_n && lock_fault_latched) else $error("no float latch");
    a_high_brake: assert property (new_lock && mode_q == 4'h2 |=>
        drive_state == 2'h2 && !fault_out_n) else $error("no high brake");
    a_low_brake: assert property (new_lock && mode_q == 4'h3 |=>
        drive_state == 2'h3 && !fault_out_n) else $error("no low brake");
    a_retry_wait: assert property (drive_state == 2'h1 && !lock_fault_latched
        |-> !fault_out_n) else $error("retry wait not reported");
    a_report_only: assert property (new_lock && mode_q == 4'h8 |=>
        drive_state == 2'h0 && !fault_out_n) else $error("report mode acted");
    a_lock_ignored: assert property (mode_q > 4'h8 && !lock_fault_active
        |=> !lock_fault_active) else $error("disabled lock reacted");
    a_latch_holds: assert property (lock_fault_latched && !fault_clear
        |=> lock_fault_latched && $stable(drive_state)) else $error("latch lost");
    a_sat_gated: assert property (current_loop_sat_flag
        |-> $past(current_loop_sat)) else $error("flag without cause");
endmodule
bind motor_lock_fault_response lock_fault_monitor i_lock_fault_monitor (.clk(clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .lock_detect(lock_detect), .fault_clear(fault_clear), .fault_out_n(fault_out_n),
    .drive_state(drive_state), .lock_fault_active(lock_fault_active),
    .lock_fault_latched(lock_fault_latched), .current_loop_sat(current_loop_sat),
    .current_loop_sat_flag(current_loop_sat_flag));

// File: stall_source.sv
// Power stage stand-in that reports a stalled rotor
`timescale 1ns/100ps
module stall_source (
    input wire clk,
    input wire stall,
    input wire [1:0] drive_state,
    output reg lock_detect
);
    initial lock_detect = 1'b0;
    // A braked or floated bridge sees no stall, so a retry is what re-arms it
    always @(posedge clk)
        lock_detect <= stall && drive_state == 2'h0;
endmodule

// File: motor_lock_fault_response_tb_top.sv
// Scenarios for the lock fault response block
`timescale 1ns/100ps
module motor_lock_fault_response_tb_top;
    reg clk = 0, rst_b = 0, reg_wr = 0, stall = 0, fault_clear = 0;
    reg pd_timeout_event = 0, pd_freq_event = 0, current_loop_sat = 0, speed_loop_sat = 0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h00000000;
    wire lock_detect, fault_out_n, lock_fault_active, lock_fault_latched, pd_timeout_fault;
    wire pd_freq_fault, current_loop_sat_flag, speed_loop_sat_flag;
    wire [1:0] drive_state;
    wire [31:0] reg_rdata;
    wire [3:0] retry_count;
    integer fails = 0, checks = 0, n, m, e;
    always #2 clk = ~clk;
    // Four cycles a millisecond keeps the longest tested retry wait (code 3) at 8000 cycles
    motor_lock_fault_response #(.MS_COUNT(4)) i_motor_lock_fault_response (.clk(clk),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .lock_detect(lock_detect), .pd_timeout_event(pd_timeout_event),
        .pd_freq_event(pd_freq_event), .current_loop_sat(current_loop_sat),
        .speed_loop_sat(speed_loop_sat), .fault_clear(fault_clear), .fault_out_n(fault_out_n),
        .drive_state(drive_state), .lock_fault_active(lock_fault_active),
        .lock_fault_latched(lock_fault_latched), .pd_timeout_fault(pd_timeout_fault),
        .pd_freq_fault(pd_freq_fault), .current_loop_sat_flag(current_loop_sat_flag),
        .speed_loop_sat_flag(speed_loop_sat_flag), .retry_count(retry_count));
    stall_source i_stall_source (.clk(clk), .stall(stall), .drive_state(drive_state),
        .lock_detect(lock_detect));
    task check(input [31:0] seen, input [31:0] exp);
    begin
        checks = checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
        end
    end
    endtask
    task final_report;
    begin
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task wreg(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
    endtask
    task rcheck(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 check(reg_rdata, d);
    end
    endtask
    task await_drive(input [1:0] ds);
    begin
        for (n = 0; drive_state !== ds && n < 9000; n = n + 1)
        begin
            @(posedge clk);
            #1;
        end
        if (n == 9000)
        begin
            fails = fails + 1;
            final_report;
        end
    end
    endtask
    task unlatch;
    begin
        @(posedge clk);
        stall <= 1'b0;
        @(posedge clk);
        fault_clear <= 1'b1;
        current_loop_sat <= 1'b0;
        speed_loop_sat <= 1'b0;
        @(posedge clk);
        fault_clear <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check({fault_out_n, drive_state}, 4);
    end
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rcheck(8'h92, 32'h00000000);
        wreg(8'h92, 32'hFFFFFFFF);
        rcheck(8'h92, 32'hFFFFFFFF);
        rcheck(8'h94, 32'h00000000);
        wreg(8'h92, 32'h00000000);
        for (m = 0; m < 16; m = m + 1)
        begin
            wreg(8'h90, (m & 3) << 7 | m << 3);
            @(posedge clk);
            stall <= 1'b1;
            if (m < 4)
            begin
                await_drive(m < 2 ? 1 : m);
                repeat (10) @(posedge clk);
                #1 check({lock_fault_latched, drive_state}, m < 2 ? 5 : m + 4);
            end
            else if (m < 8)
            begin
                await_drive(1);
                await_drive(0);
                e = (m == 4) ? 1200 : (m == 5) ? 2000 : (m - 5) * 4000;
                check(n >= e - 1 && n <= e + 2, 1);
                await_drive(m < 6 ? 1 : m - 4);
                check(lock_fault_latched, 1);
                check({lock_fault_active, retry_count}, 5'h11);
            end
            else
            begin
                repeat (3) @(posedge clk);
                #1 check({fault_out_n, drive_state}, m > 8 ? 4 : 0);
            end
            unlatch;
        end
        for (m = 0; m < 2; m = m + 1)
        begin
            wreg(8'h90, 32'h00000048 | m * 7);
            @(posedge clk);
            pd_timeout_event <= 1'b1;
            pd_freq_event <= 1'b1;
            current_loop_sat <= 1'b1;
            speed_loop_sat <= 1'b1;
            @(posedge clk);
            pd_timeout_event <= 1'b0;
            pd_freq_event <= 1'b0;
            repeat (2) @(posedge clk);
            #1 check({pd_timeout_fault, pd_freq_fault}, m * 3);
            check({current_loop_sat_flag, speed_loop_sat_flag}, m * 3);
            unlatch;
        end
        final_report;
    end
endmodule
